//--- design/sd_cfg_ext_defs.svh
/*
  Constants for the SD host configuration extension registers:
  configuration offsets, field positions, reset values, debounce timing.
  Assumes it is included by bare name wherever those values are needed.
*/
`ifndef SD_CFG_EXT_DEFS_SVH
`define SD_CFG_EXT_DEFS_SVH

// ==========================================================================
// Configuration offsets (byte addresses of dwords)
`define CFG_OFF_SUBSYS_HDR      8'h2C
`define CFG_OFF_SUBSYS_ALIAS    8'h8C
`define CFG_OFF_DEBOUNCE_TEST   8'h90
`define CFG_OFF_SLOT0_CUR       8'h94

// ==========================================================================
// Field positions
`define SUBSYS_DEV_MSB          31
`define SUBSYS_DEV_LSB          16
`define SUBSYS_MAKER_MSB        15
`define SUBSYS_MAKER_LSB        0
`define DEBOUNCE_TEST_BIT       16
`define SLOT0_CUR_MSB           7

// ==========================================================================
// Reset values
`define SUBSYS_ALIAS_RESET      32'h0000_0000
`define DEBOUNCE_TEST_RESET     1'h0
`define SLOT0_CUR_RESET         8'h00

// ==========================================================================
// Timing
`define CORE_CLK_MHZ            50
`define CD_NORMAL_TIME_US       1000
`define CD_SHORT_TIME_US        2
`define CD_NORMAL_CYCLES        (`CD_NORMAL_TIME_US * `CORE_CLK_MHZ)
`define CD_SHORT_CYCLES         (`CD_SHORT_TIME_US * `CORE_CLK_MHZ)

`endif

//--- design/sd_cfg_ext_pkg.sv
/*
  Types shared by the SD host configuration extension design.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sd_cfg_ext_pkg;

  // ========================================================================
  // Card-detect filter states
  typedef enum logic [1:0] {
    CD_STABLE = 2'b01,
    CD_SETTLE = 2'b10
  } cd_state_t;

endpackage

//--- design/card_detect_filter.sv
/*
  Card-detect debounce filter with a normal and a shortened settle time.
  Assumes its detect input is already synchronised to clk_in.
*/
`timescale 1ns/100ps
`include "sd_cfg_ext_defs.svh"

module card_detect_filter #(
  parameter int unsigned        CNT_W        = 20,
  parameter logic [CNT_W-1:0]   NORMAL_COUNT = CNT_W'(`CD_NORMAL_CYCLES),
  parameter logic [CNT_W-1:0]   SHORT_COUNT  = CNT_W'(`CD_SHORT_CYCLES)
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic detect_in,
  input  wire logic short_mode_in,
  output logic      present_out
);

  sd_cfg_ext_pkg::cd_state_t state_q, state_d;
  logic [CNT_W-1:0]          cnt_q, cnt_d;
  logic                      present_q, present_d;
  logic [CNT_W-1:0]          limit;

  // ========================================================================
  // Settle counter
  always_comb begin
    limit     = short_mode_in ? SHORT_COUNT : NORMAL_COUNT;
    state_d   = state_q;
    cnt_d     = cnt_q;
    present_d = present_q;
    case (state_q)
      sd_cfg_ext_pkg::CD_STABLE: begin
        cnt_d = '0;
        if (detect_in != present_q) begin
          state_d = sd_cfg_ext_pkg::CD_SETTLE;
        end
      end
      sd_cfg_ext_pkg::CD_SETTLE: begin
        // Any bounce restarts the wait
        if (detect_in == present_q) begin
          state_d = sd_cfg_ext_pkg::CD_STABLE;
          cnt_d   = '0;
        end else if (cnt_q + CNT_W'(1) >= limit) begin
          present_d = detect_in;
          state_d   = sd_cfg_ext_pkg::CD_STABLE;
          cnt_d     = '0;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      default: begin
        state_d = sd_cfg_ext_pkg::CD_STABLE;
        cnt_d   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q   <= sd_cfg_ext_pkg::CD_STABLE;
      cnt_q     <= '0;
      present_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      present_q <= present_d;
    end
  end

  assign present_out = present_q;

  // ========================================================================
  // Assertions
  // A wait begun under the long count is cut to the short limit when short mode arrives
  property p_short_mode;
    @(posedge clk_in) disable iff (!rst_n_in)
    short_mode_in |=> cnt_q < SHORT_COUNT;
  endproperty
  a_short_mode: assert property (p_short_mode)
    else $error("settle count ran past the short debounce limit");

endmodule // card_detect_filter

//--- design/sd_host_config_extension_regs.sv
/*
  Vendor configuration registers of the SD host function: subsystem
  identifier alias, debounce test control and slot 0 3.3-V current alias,
  plus the card-detect filter they steer.
  Assumes a configuration-cycle front end on core_clk_in that raises a
  one-cycle request with dword address and byte enables.
*/
// Behaviour
// - Alias bits 31..16 appear as the subsystem device identifier at 2Eh.
// - Alias bits 15..0 appear as the subsystem vendor identifier at 2Ch.
// - Alias and diagnostic registers clear only on global reset.
// - Diagnostic bit 16 set selects shortened card-detect debounce times.
// - Diagnostic bits 31..17 and 15..0 read zero, writes ignored.
// - Slot 0 current register mirrors into the 3.3-V maximum current field.
// - Slot 0 current register clears only on global reset.
`timescale 1ns/100ps
`include "sd_cfg_ext_defs.svh"

module sd_host_config_extension_regs #(
  parameter int unsigned CD_CNT_W        = 20,
  parameter int unsigned CD_NORMAL_COUNT = `CD_NORMAL_CYCLES
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        global_reset_n_in,
  input  wire logic        cfg_req_in,
  input  wire logic        cfg_we_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [3:0]  cfg_be_in,
  input  wire logic [31:0] cfg_wdata_in,
  input  wire logic        card_detect_n_in,
  output logic             cfg_ack_out,
  output logic [31:0]      cfg_rdata_out,
  output logic [15:0]      subsys_device_ident_out,
  output logic [15:0]      subsys_maker_ident_out,
  output logic [7:0]       slot0_max_current_3v3_out,
  output logic             debounce_short_out,
  output logic             card_present_out
);

  // ========================================================================
  // Reset synchronisers
  logic core_rst_meta_q, core_rst_q;
  logic gl_rst_meta_q, gl_rst_q;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_rst_meta_q <= 1'b0;
      core_rst_q      <= 1'b0;
    end else begin
      core_rst_meta_q <= 1'b1;
      core_rst_q      <= core_rst_meta_q;
    end
  end

  always_ff @(posedge core_clk_in or negedge global_reset_n_in) begin
    if (!global_reset_n_in) begin
      gl_rst_meta_q <= 1'b0;
      gl_rst_q      <= 1'b0;
    end else begin
      gl_rst_meta_q <= 1'b1;
      gl_rst_q      <= gl_rst_meta_q;
    end
  end

  // ========================================================================
  // Card-detect pin synchroniser
  logic cd_meta_q, cd_sync_q;

  always_ff @(posedge core_clk_in or negedge core_rst_q) begin
    if (!core_rst_q) begin
      cd_meta_q <= 1'b1;
      cd_sync_q <= 1'b1;
    end else begin
      cd_meta_q <= card_detect_n_in;
      cd_sync_q <= cd_meta_q;
    end
  end

  // ========================================================================
  // Global-reset-only registers
  logic [31:0] alias_q, alias_d;
  logic        diag_q, diag_d;
  logic [7:0]  cur_q, cur_d;
  logic        wr_en;

  assign wr_en = cfg_req_in && cfg_we_in && core_rst_q;

  always_comb begin
    alias_d = alias_q;
    diag_d  = diag_q;
    cur_d   = cur_q;
    if (wr_en && cfg_addr_in == `CFG_OFF_SUBSYS_ALIAS) begin
      for (int i = 0; i < 4; i++) begin
        if (cfg_be_in[i]) begin
          alias_d[i*8 +: 8] = cfg_wdata_in[i*8 +: 8];
        end
      end
    end
    if (wr_en && cfg_addr_in == `CFG_OFF_DEBOUNCE_TEST && cfg_be_in[2]) begin
      diag_d = cfg_wdata_in[`DEBOUNCE_TEST_BIT];
    end
    if (wr_en && cfg_addr_in == `CFG_OFF_SLOT0_CUR && cfg_be_in[0]) begin
      cur_d = cfg_wdata_in[`SLOT0_CUR_MSB:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge gl_rst_q) begin
    if (!gl_rst_q) begin
      alias_q <= `SUBSYS_ALIAS_RESET;
      diag_q  <= `DEBOUNCE_TEST_RESET;
      cur_q   <= `SLOT0_CUR_RESET;
    end else begin
      alias_q <= alias_d;
      diag_q  <= diag_d;
      cur_q   <= cur_d;
    end
  end

  // ========================================================================
  // Read path, one cycle after the request
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    ack_d   = cfg_req_in && core_rst_q;
    rdata_d = 32'h0000_0000;
    if (cfg_req_in && !cfg_we_in && core_rst_q) begin
      case (cfg_addr_in)
        // header and alias read the same flops
        `CFG_OFF_SUBSYS_HDR:    rdata_d = alias_q;
        `CFG_OFF_SUBSYS_ALIAS:  rdata_d = alias_q;
        `CFG_OFF_DEBOUNCE_TEST: rdata_d[`DEBOUNCE_TEST_BIT] = diag_q;
        `CFG_OFF_SLOT0_CUR:     rdata_d[`SLOT0_CUR_MSB:0] = cur_q;
        default:                rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge core_rst_q) begin
    if (!core_rst_q) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // ========================================================================
  // Debounce filter; long count kept as a parameter so simulation can shrink it
  // test bit picks short settle
  card_detect_filter #(
    .CNT_W        (CD_CNT_W),
    .NORMAL_COUNT (CD_CNT_W'(CD_NORMAL_COUNT)),
    .SHORT_COUNT  (CD_CNT_W'(`CD_SHORT_CYCLES))
  ) u_cd_filter (
    .clk_in        (core_clk_in),
    .rst_n_in      (core_rst_q),
    .detect_in     (!cd_sync_q),
    .short_mode_in (diag_q),
    .present_out   (card_present_out)
  );

  assign cfg_ack_out               = ack_q;
  assign cfg_rdata_out             = rdata_q;
  assign subsys_device_ident_out   = alias_q[`SUBSYS_DEV_MSB:`SUBSYS_DEV_LSB];
  assign subsys_maker_ident_out    = alias_q[`SUBSYS_MAKER_MSB:`SUBSYS_MAKER_LSB];
  assign slot0_max_current_3v3_out = cur_q;
  assign debounce_short_out        = diag_q;

  // ========================================================================
  // Assertions
  sequence s_wr_alias;
    cfg_req_in && cfg_we_in && core_rst_q && cfg_addr_in == `CFG_OFF_SUBSYS_ALIAS;
  endsequence

  sequence s_rd_hdr;
    cfg_req_in && !cfg_we_in && core_rst_q && cfg_addr_in == `CFG_OFF_SUBSYS_HDR;
  endsequence

  property p_dev_alias;
    @(posedge core_clk_in) disable iff (!gl_rst_q)
    s_wr_alias and (cfg_be_in[3:2] == 2'b11) |=>
      subsys_device_ident_out == $past(cfg_wdata_in[31:16]);
  endproperty
  a_dev_alias: assert property (p_dev_alias)
    else $error("device ident not updated from alias write");

  property p_maker_alias;
    @(posedge core_clk_in) disable iff (!gl_rst_q)
    s_wr_alias and (cfg_be_in[1:0] == 2'b11) |=>
      subsys_maker_ident_out == $past(cfg_wdata_in[15:0]);
  endproperty
  a_maker_alias: assert property (p_maker_alias)
    else $error("vendor ident not updated from alias write");

  property p_global_clear;
    @(posedge core_clk_in)
    $rose(gl_rst_q) |-> alias_q == 32'h0000_0000 && !diag_q;
  endproperty
  a_global_clear: assert property (p_global_clear)
    else $error("alias or diagnostic not clear after global reset");

  property p_diag_reserved;
    @(posedge core_clk_in) disable iff (!core_rst_q)
    cfg_req_in && !cfg_we_in && cfg_addr_in == `CFG_OFF_DEBOUNCE_TEST |=>
      cfg_ack_out && cfg_rdata_out[31:17] == 15'h0000 && cfg_rdata_out[15:0] == 16'h0000;
  endproperty
  a_diag_reserved: assert property (p_diag_reserved)
    else $error("diagnostic reserved bits read nonzero");

  property p_cur_mirror;
    @(posedge core_clk_in) disable iff (!gl_rst_q)
    cfg_req_in && cfg_we_in && core_rst_q && cfg_be_in[0]
      && cfg_addr_in == `CFG_OFF_SLOT0_CUR |=>
      slot0_max_current_3v3_out == $past(cfg_wdata_in[7:0]);
  endproperty
  a_cur_mirror: assert property (p_cur_mirror)
    else $error("slot 0 current field not mirrored");

  property p_keep_core_reset;
    @(posedge core_clk_in) disable iff (!gl_rst_q)
    !core_rst_q |=> $stable(cur_q) && $stable(alias_q) && $stable(diag_q);
  endproperty
  a_keep_core_reset: assert property (p_keep_core_reset)
    else $error("global-only register changed during core reset");

  property p_hdr_read;
    @(posedge core_clk_in) disable iff (!core_rst_q || !gl_rst_q)
    s_rd_hdr |=> cfg_ack_out && cfg_rdata_out == $past(alias_q);
  endproperty
  a_hdr_read: assert property (p_hdr_read)
    else $error("header read does not return alias contents");

endmodule // sd_host_config_extension_regs

//--- test/testbench.sv
/*
  Self-checking bench for the SD host configuration extension registers.
  Assumes the design files under design/ are compiled before it.
*/
`timescale 1ns/100ps

module testbench;
  // ==========================================================================
  // Signals and model state
  localparam int NORM  = 400;
  localparam int SHORT = 100;
  logic        core_clk_in;
  logic        rst_n_in;
  logic        global_reset_n_in;
  logic        cfg_req_in;
  logic        cfg_we_in;
  logic [7:0]  cfg_addr_in;
  logic [3:0]  cfg_be_in;
  logic [31:0] cfg_wdata_in;
  logic        card_detect_n_in;
  logic        cfg_ack_out;
  logic [31:0] cfg_rdata_out;
  logic [15:0] subsys_device_ident_out;
  logic [15:0] subsys_maker_ident_out;
  logic [7:0]  slot0_max_current_3v3_out;
  logic        debounce_short_out;
  logic        card_present_out;
  int          mismatches;
  int          n_checks;
  int          n;
  logic [31:0] rnd;
  logic [31:0] alias_m;
  logic [31:0] diag_m;
  logic [31:0] cur_m;
  logic [7:0]  wr_tab [4] = '{8'h8C, 8'h90, 8'h94, 8'hA0};
  logic [7:0]  rd_tab [5] = '{8'h2C, 8'h8C, 8'h90, 8'h94, 8'h30};

  sd_host_config_extension_regs #(
    .CD_CNT_W        (20),
    .CD_NORMAL_COUNT (NORM)
  ) sd_host_config_extension_regs_inst (
    .core_clk_in               (core_clk_in),
    .rst_n_in                  (rst_n_in),
    .global_reset_n_in         (global_reset_n_in),
    .cfg_req_in                (cfg_req_in),
    .cfg_we_in                 (cfg_we_in),
    .cfg_addr_in               (cfg_addr_in),
    .cfg_be_in                 (cfg_be_in),
    .cfg_wdata_in              (cfg_wdata_in),
    .card_detect_n_in          (card_detect_n_in),
    .cfg_ack_out               (cfg_ack_out),
    .cfg_rdata_out             (cfg_rdata_out),
    .subsys_device_ident_out   (subsys_device_ident_out),
    .subsys_maker_ident_out    (subsys_maker_ident_out),
    .slot0_max_current_3v3_out (slot0_max_current_3v3_out),
    .debounce_short_out        (debounce_short_out),
    .card_present_out          (card_present_out)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] next_rnd(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h2C, 8'h8C: return alias_m;
      8'h90:        return diag_m;
      8'h94:        return cur_m;
      default:      return 32'h0000_0000;
    endcase
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check_outs;
    check("device ident", {16'h0000, subsys_device_ident_out}, alias_m >> 16);
    check("maker ident", {16'h0000, subsys_maker_ident_out}, alias_m & 32'h0000_FFFF);
    check("slot0 current", {24'h000000, slot0_max_current_3v3_out}, cur_m);
    check("short mode", {31'h0, debounce_short_out}, diag_m >> 16);
  endtask

  // One-cycle request, answer exactly one cycle later
  task automatic cfg(input logic we, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge core_clk_in);
    #1;
    cfg_req_in   = 1'b1;
    cfg_we_in    = we;
    cfg_addr_in  = a;
    cfg_be_in    = be;
    cfg_wdata_in = wd;
    @(posedge core_clk_in);
    #1;
    cfg_req_in = 1'b0;
    check("ack", {31'h0, cfg_ack_out}, 32'h1);
    rdv = cfg_rdata_out;
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] r;
    cfg(1'b1, a, be, wd, r);
    // Byte lanes; reserved diag bits never stored
    for (int i = 0; i < 4; i++)
      if (a == 8'h8C && be[i]) alias_m[i*8 +: 8] = wd[i*8 +: 8];
    if (a == 8'h90 && be[2]) diag_m[16] = wd[16];
    if (a == 8'h94 && be[0]) cur_m[7:0] = wd[7:0];
    check("write rdata", r, 32'h0000_0000);
    check_outs();
  endtask

  task automatic rd_chk(input logic [7:0] a);
    logic [31:0] r;
    cfg(1'b0, a, 4'hF, 32'h0000_0000, r);
    check("read data", r, exp_rd(a));
  endtask

  task automatic settle(input logic lvl, input int cnt);
    n = 0;
    while (card_present_out !== lvl && n < 2000) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    if (n >= 2000) begin
      mismatches++;
      test_done();
    end else begin
      check("settle time ok", {31'h0, (n >= cnt - 2 && n <= cnt + 8)}, 32'h1);
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {cfg_req_in, cfg_we_in, cfg_addr_in, cfg_be_in, cfg_wdata_in} = '0;
    {rst_n_in, global_reset_n_in, card_detect_n_in} = 3'b001;
    {mismatches, n_checks} = 0;
    {alias_m, diag_m, cur_m} = '0;
    rnd = 32'h291b0907;
    repeat (5) @(posedge core_clk_in);
    #1;
    {rst_n_in, global_reset_n_in} = 2'b11;
    repeat (4) @(posedge core_clk_in);
    // Reset values of all three registers
    foreach (rd_tab[i]) rd_chk(rd_tab[i]);
    check_outs();
    for (int k = 0; k < 40; k++) begin
      rnd = next_rnd(rnd);
      wr(wr_tab[rnd[1:0]], rnd[7:4], next_rnd(rnd));
      rnd = next_rnd(rnd);
      rd_chk(rd_tab[rnd[2:0] % 5]);
    end
    wr(8'h8C, 4'hF, rnd);
    wr(8'h94, 4'h1, 32'hFFFF_FFA5);
    wr(8'h90, 4'h4, 32'hFFFF_FFFF);
    // Core reset must leave the registers alone
    rst_n_in = 1'b0;
    repeat (3) @(posedge core_clk_in);
    #1 rst_n_in = 1'b1;
    repeat (4) @(posedge core_clk_in);
    #1;
    check_outs();
    foreach (rd_tab[i]) rd_chk(rd_tab[i]);
    // Only global reset clears them
    global_reset_n_in = 1'b0;
    {alias_m, diag_m, cur_m} = '0;
    repeat (3) @(posedge core_clk_in);
    #1 global_reset_n_in = 1'b1;
    repeat (4) @(posedge core_clk_in);
    #1;
    check_outs();
    foreach (rd_tab[i]) rd_chk(rd_tab[i]);
    // Normal debounce, then shortened one
    card_detect_n_in = 1'b0;
    settle(1'b1, NORM);
    wr(8'h90, 4'h4, 32'h0001_0000);
    card_detect_n_in = 1'b1;
    settle(1'b0, SHORT);
    test_done();
  end
endmodule // testbench
